// ===== rtl/cofc_defines.vh
// constants for the channel output format configuration bank
// assumes an 8-bit register port addressed at the documented offsets
`ifndef COFC_DEFINES_VH
`define COFC_DEFINES_VH
`define COFC_ADDR_CH0_CFG 8'h42
`define COFC_ADDR_CH1_CFG 8'h4A
`define COFC_CFG_RESET 8'h00
`define COFC_UNSIGNED_BIT 7
`define COFC_PRIMARY_MSB 6
`define COFC_PRIMARY_LSB 5
`define COFC_SECONDARY_MSB 4
`define COFC_SECONDARY_LSB 2
`define COFC_AVG_MSB 1
`define COFC_AVG_LSB 0
`define COFC_MODE_DSI3 3'h0
`define COFC_MODE_SPI 3'h1
`define COFC_MODE_I2C 3'h2
`define COFC_MODE_PSI5_PROG 3'h3
`define COFC_PERIOD_32_US 32
`define COFC_PERIOD_64_US 64
`define COFC_PERIOD_128_US 128
`define COFC_CLK_MHZ 100
`define COFC_CYC_32 (`COFC_PERIOD_32_US * `COFC_CLK_MHZ)
`define COFC_CYC_64 (`COFC_PERIOD_64_US * `COFC_CLK_MHZ)
`define COFC_CYC_128 (`COFC_PERIOD_128_US * `COFC_CLK_MHZ)
`define COFC_DSP_INIT_CYCLES 16'h0100
`endif

// ===== rtl/cofc_channel_scale.v
// one channel: sensitivity scaling and output sign format
// assumes trimmed sample arrives already aligned as a signed 16-bit word
`timescale 1ns/1ns
`default_nettype none
module cofc_channel_scale
(
  input wire clock_i,
  input wire srst_i,
  input wire [15:0] sample_i,
  input wire [1:0] user_gain_shift_i,
  input wire [7:0] user_gain_multiplier_i,
  input wire unsigned_output_select_i,
  output reg [15:0] scaled_o
);
  reg [26:0] product;
  reg [26:0] shifted;
  reg [15:0] signed_word;
  always @*
  begin
    // (256 + mult) * sample; any shift and multiplier pairing is legal
    product = $signed(sample_i) * $signed({2'b00, 9'h100 + {1'b0, user_gain_multiplier_i}});
    // shift codes 0..3 give 0.25, 0.5, 1, 2; >>8 for the /256 term
    case (user_gain_shift_i)
      2'h0: shifted = $signed(product) >>> 10;
      2'h1: shifted = $signed(product) >>> 9;
      2'h2: shifted = $signed(product) >>> 8;
      default: shifted = $signed(product) >>> 7;
    endcase
    signed_word = shifted[15:0];
  end
  always @(posedge clock_i)
  begin
    if (srst_i)
      scaled_o <= 16'h0000;
    else if (unsigned_output_select_i)
      scaled_o <= {~signed_word[15], signed_word[14:0]};
    else
      scaled_o <= signed_word;
  end
endmodule
`default_nettype wire

// ===== rtl/cofc_bank.v
// Overview of operation
// - registers accessible in DSI3, SPI, I2C, PSI5 programming
// - both registers included in array error check
// - one read/write format register per channel
// - 8-bit layout, channel copies at 0x42, 0x4A
// - unsigned select chooses signed or offset-binary output; temperature passes unchanged
// - shift code gives 0.25, 0.5, 1, 2
// - primary type: offset data, raw data, temperature
// - average select: bypass, or 8-sample at 32/64/128us
// - average select change by register write resets DSP data path; an otp load does not
//
// holds the two format registers, decodes fields, drives the channel paths
// assumes register port strobes are one cycle and synchronous to clock_i
`timescale 1ns/1ns
`default_nettype none
`include "cofc_defines.vh"
module cofc_bank
(
  input wire clock_i,
  input wire srst_i,
  input wire [2:0] link_mode_i,
  input wire psi5_prog_i,
  input wire otp_load_i,
  input wire [7:0] otp_ch0_cfg_i,
  input wire [7:0] otp_ch1_cfg_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output wire reg_hit_o,
  output wire [7:0] array_check_o,
  input wire [1:0] ch0_user_gain_shift_i,
  input wire [7:0] ch0_user_gain_multiplier_i,
  input wire [1:0] ch1_user_gain_shift_i,
  input wire [7:0] ch1_user_gain_multiplier_i,
  input wire [15:0] ch0_sample_i,
  input wire [15:0] ch1_sample_i,
  input wire [15:0] ch0_raw_i,
  input wire [15:0] ch1_raw_i,
  input wire [15:0] temperature_i,
  output reg [15:0] ch0_result_word0_o,
  output reg [15:0] ch1_result_word0_o,
  output wire [2:0] ch0_secondary_output_type_sel_o,
  output wire [2:0] ch1_secondary_output_type_sel_o,
  output wire [1:0] ch0_interp_avg_o,
  output wire [1:0] ch1_interp_avg_o,
  output wire [13:0] ch0_avg_period_cycles_o,
  output wire [13:0] ch1_avg_period_cycles_o,
  output wire [1:0] dsp_reset_o,
  output wire [1:0] dsp_ready_o
);
  reg [7:0] ch0_cfg_reg;
  reg [7:0] ch1_cfg_reg;
  reg [15:0] ch0_init_reg;
  reg [15:0] ch1_init_reg;
  reg [1:0] dsp_reset_reg;
  wire access_ok;
  wire wr0;
  wire wr1;
  wire avg_change0;
  wire avg_change1;
  wire [15:0] ch0_scaled;
  wire [15:0] ch1_scaled;
  reg [1:0] ch0_interp_avg;
  reg [1:0] ch1_interp_avg;
  reg [13:0] ch0_period;
  reg [13:0] ch1_period;
  // full-width copies; the 14-bit period ports take the low bits, which hold every value
  localparam [31:0] avg_cyc32_full = `COFC_CYC_32;
  localparam [31:0] avg_cyc64_full = `COFC_CYC_64;
  localparam [31:0] avg_cyc128_full = `COFC_CYC_128;

  assign access_ok = (link_mode_i == `COFC_MODE_DSI3) || (link_mode_i == `COFC_MODE_SPI) ||
    (link_mode_i == `COFC_MODE_I2C) || ((link_mode_i == `COFC_MODE_PSI5_PROG) && psi5_prog_i);
  assign reg_hit_o = access_ok && ((reg_addr_i == `COFC_ADDR_CH0_CFG) || (reg_addr_i == `COFC_ADDR_CH1_CFG));
  assign wr0 = reg_wr_i && access_ok && (reg_addr_i == `COFC_ADDR_CH0_CFG);
  assign wr1 = reg_wr_i && access_ok && (reg_addr_i == `COFC_ADDR_CH1_CFG);
  assign avg_change0 = wr0 && (reg_wdata_i[`COFC_AVG_MSB:`COFC_AVG_LSB] != ch0_cfg_reg[`COFC_AVG_MSB:`COFC_AVG_LSB]);
  assign avg_change1 = wr1 && (reg_wdata_i[`COFC_AVG_MSB:`COFC_AVG_LSB] != ch1_cfg_reg[`COFC_AVG_MSB:`COFC_AVG_LSB]);

  // per-channel storage, otp image loads first; a write in the same cycle wins
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ch0_cfg_reg <= `COFC_CFG_RESET;
      ch1_cfg_reg <= `COFC_CFG_RESET;
    end
    else
    begin
      if (wr0)
        ch0_cfg_reg <= reg_wdata_i;
      else if (otp_load_i)
        ch0_cfg_reg <= otp_ch0_cfg_i;
      if (wr1)
        ch1_cfg_reg <= reg_wdata_i;
      else if (otp_load_i)
        ch1_cfg_reg <= otp_ch1_cfg_i;
    end
  end

  always @*
  begin
    reg_rdata_o = 8'h00;
    if (reg_rd_i && access_ok && (reg_addr_i == `COFC_ADDR_CH0_CFG))
      reg_rdata_o = ch0_cfg_reg;
    else if (reg_rd_i && access_ok && (reg_addr_i == `COFC_ADDR_CH1_CFG))
      reg_rdata_o = ch1_cfg_reg;
  end

  // both bytes folded into the array error check contribution
  assign array_check_o = ch0_cfg_reg ^ {ch1_cfg_reg[6:0], ch1_cfg_reg[7]};

  // data path reset pulses for one cycle; ready drops in that same cycle and stays low while the init counter runs; reads not guaranteed then
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ch0_init_reg <= 16'h0000;
      ch1_init_reg <= 16'h0000;
      dsp_reset_reg <= 2'b00;
    end
    else
    begin
      dsp_reset_reg <= {avg_change1, avg_change0};
      if (avg_change0)
        ch0_init_reg <= `COFC_DSP_INIT_CYCLES;
      else if (ch0_init_reg != 16'h0000)
        ch0_init_reg <= ch0_init_reg - 16'h0001;
      if (avg_change1)
        ch1_init_reg <= `COFC_DSP_INIT_CYCLES;
      else if (ch1_init_reg != 16'h0000)
        ch1_init_reg <= ch1_init_reg - 16'h0001;
    end
  end
  assign dsp_reset_o = dsp_reset_reg;
  assign dsp_ready_o = {ch1_init_reg == 16'h0000, ch0_init_reg == 16'h0000};

  // bit 1 = averaging on, bit 0 = interpolation on; code 00 bypasses the average
  always @*
  begin
    ch0_interp_avg = 2'b10;
    ch0_period = 14'h0000;
    case (ch0_cfg_reg[`COFC_AVG_MSB:`COFC_AVG_LSB])
      2'b00:
      begin
        ch0_interp_avg = 2'b01;
        ch0_period = 14'h0000;
      end
      2'b01: ch0_period = avg_cyc32_full[13:0];
      2'b10: ch0_period = avg_cyc64_full[13:0];
      default: ch0_period = avg_cyc128_full[13:0];
    endcase
  end
  always @*
  begin
    ch1_interp_avg = 2'b10;
    ch1_period = 14'h0000;
    case (ch1_cfg_reg[`COFC_AVG_MSB:`COFC_AVG_LSB])
      2'b00:
      begin
        ch1_interp_avg = 2'b01;
        ch1_period = 14'h0000;
      end
      2'b01: ch1_period = avg_cyc32_full[13:0];
      2'b10: ch1_period = avg_cyc64_full[13:0];
      default: ch1_period = avg_cyc128_full[13:0];
    endcase
  end
  assign ch0_interp_avg_o = ch0_interp_avg;
  assign ch1_interp_avg_o = ch1_interp_avg;
  assign ch0_avg_period_cycles_o = ch0_period;
  assign ch1_avg_period_cycles_o = ch1_period;
  assign ch0_secondary_output_type_sel_o = ch0_cfg_reg[`COFC_SECONDARY_MSB:`COFC_SECONDARY_LSB];
  assign ch1_secondary_output_type_sel_o = ch1_cfg_reg[`COFC_SECONDARY_MSB:`COFC_SECONDARY_LSB];

  cofc_channel_scale u_scale0
  (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .sample_i(ch0_sample_i),
    .user_gain_shift_i(ch0_user_gain_shift_i),
    .user_gain_multiplier_i(ch0_user_gain_multiplier_i),
    .unsigned_output_select_i(ch0_cfg_reg[`COFC_UNSIGNED_BIT]),
    .scaled_o(ch0_scaled)
  );
  cofc_channel_scale u_scale1
  (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .sample_i(ch1_sample_i),
    .user_gain_shift_i(ch1_user_gain_shift_i),
    .user_gain_multiplier_i(ch1_user_gain_multiplier_i),
    .unsigned_output_select_i(ch1_cfg_reg[`COFC_UNSIGNED_BIT]),
    .scaled_o(ch1_scaled)
  );

  // raw data gets the same sign format; temperature passes unchanged
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ch0_result_word0_o <= 16'h0000;
      ch1_result_word0_o <= 16'h0000;
    end
    else
    begin
      case (ch0_cfg_reg[`COFC_PRIMARY_MSB:`COFC_PRIMARY_LSB])
        2'b00: ch0_result_word0_o <= ch0_scaled;
        2'b01: ch0_result_word0_o <= {ch0_raw_i[15] ^ ch0_cfg_reg[`COFC_UNSIGNED_BIT], ch0_raw_i[14:0]};
        default: ch0_result_word0_o <= temperature_i;
      endcase
      case (ch1_cfg_reg[`COFC_PRIMARY_MSB:`COFC_PRIMARY_LSB])
        2'b00: ch1_result_word0_o <= ch1_scaled;
        2'b01: ch1_result_word0_o <= {ch1_raw_i[15] ^ ch1_cfg_reg[`COFC_UNSIGNED_BIT], ch1_raw_i[14:0]};
        default: ch1_result_word0_o <= temperature_i;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verification/cofc_host.sv
// host controller model: issues register reads and writes on the bank port
// assumes one access at a time, signals changed just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module cofc_host
(
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic [7:0] reg_wdata_o = 8'h00
);
  // released lines show the inverse of their last value, never a stale copy
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clock_i);
    d = reg_rdata_i;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
  endtask
endmodule
`default_nettype wire

// ===== verification/cofc_monitor.sv
// checker for the format bank; watches only the bank's ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module cofc_monitor
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [2:0] link_mode_i,
  input wire logic psi5_prog_i,
  input wire logic otp_load_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic [7:0] array_check_o,
  input wire logic [2:0] ch0_secondary_output_type_sel_o,
  input wire logic [1:0] ch0_interp_avg_o,
  input wire logic [13:0] ch0_avg_period_cycles_o,
  input wire logic [1:0] dsp_reset_o,
  input wire logic [1:0] dsp_ready_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire w0 = reg_wr_i && reg_hit_o && reg_addr_i == 8'h42;
  wire [2:0] wsec = reg_wdata_i[4:2];
  wire [13:0] wper = (reg_wdata_i[1:0] == 2'h0) ? 14'h0000 : (14'h0C80 << (reg_wdata_i[1:0] - 2'h1));
  // cycles since the last data-path reset pulse, saturating
  logic [9:0] cnt_reg;
  always @(posedge clock_i)
  begin
    if (srst_i) cnt_reg <= 10'h000;
    else if (dsp_reset_o[0]) cnt_reg <= 10'h001;
    else if (cnt_reg != 10'h3FF) cnt_reg <= cnt_reg + 10'h001;
  end
  chk_hit_allowed: assert property (
    (reg_wr_i || reg_rd_i) && reg_addr_i == 8'h4A && link_mode_i < 3'h3 |-> reg_hit_o) else $error("no hit");
  chk_refused_read: assert property (
    reg_rd_i && (link_mode_i > 3'h3 || (link_mode_i == 3'h3 && !psi5_prog_i)) |-> !reg_hit_o && reg_rdata_o == 8'h00)
    else $error("refused access answered");
  chk_write_read: assert property (
    w0 ##1 (!reg_wr_i && !otp_load_i) ##1 (reg_rd_i && reg_hit_o && reg_addr_i == 8'h42)
    |-> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("readback differs");
  chk_field_map: assert property (
    w0 |=> ch0_secondary_output_type_sel_o == $past(wsec)) else $error("secondary field wrong");
  chk_avg_period: assert property (
    w0 |=> ch0_avg_period_cycles_o == $past(wper) && ch0_interp_avg_o == (($past(wper) == 14'h0000) ? 2'b01 : 2'b10))
    else $error("average decode wrong");
  chk_dsp_pulse: assert property (
    w0 && wper != ch0_avg_period_cycles_o |=> dsp_reset_o[0] ##1 !dsp_reset_o[0]) else $error("no reset pulse");
  chk_init_len: assert property (
    $rose(dsp_ready_o[0]) |-> cnt_reg >= 10'h0FA && cnt_reg <= 10'h104) else $error("init length wrong");
  chk_fold_cover: assert property (
    $changed(ch0_secondary_output_type_sel_o) && !$past(otp_load_i) |-> $changed(array_check_o))
    else $error("check word ignores register");
  chk_reset_state: assert property (disable iff (1'b0)
    srst_i |=> dsp_ready_o == 2'b11 && dsp_reset_o == 2'b00 && ch0_avg_period_cycles_o == 14'h0000)
    else $error("reset state wrong");
endmodule
bind cofc_bank cofc_monitor u_mon
(
  .clock_i(clock_i),
  .srst_i(srst_i),
  .link_mode_i(link_mode_i),
  .psi5_prog_i(psi5_prog_i),
  .otp_load_i(otp_load_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_hit_o(reg_hit_o),
  .array_check_o(array_check_o),
  .ch0_secondary_output_type_sel_o(ch0_secondary_output_type_sel_o),
  .ch0_interp_avg_o(ch0_interp_avg_o),
  .ch0_avg_period_cycles_o(ch0_avg_period_cycles_o),
  .dsp_reset_o(dsp_reset_o),
  .dsp_ready_o(dsp_ready_o)
);
`default_nettype wire

// ===== verification/channel_output_format_config_bench.sv
// self-checking bench for the format bank, driven through the host model
// assumes 100 MHz clock and scaling sample*(256+mult)>>(10-shift)
`timescale 1ns/1ns
`default_nettype none
`include "cofc_defines.vh"
module channel_output_format_config_bench;
  logic clock_i = 1'b0, srst_i = 1'b1, prog = 1'b0, otp = 1'b0, wr, rd;
  logic [2:0] mode = 3'h1;
  logic [1:0] sh = 2'h2;
  logic [7:0] mul = 8'h00, addr, wd, rdat, o0 = 8'h00, o1 = 8'h00;
  logic [15:0] smp = 16'h0100, raw = 16'h0222, tmp = 16'h0333;
  wire [15:0] r0, r1;
  wire [13:0] p0, p1;
  wire [2:0] s1;
  wire [1:0] i1;
  wire [1:0] rdy;
  int failures = 0, n_compared = 0, k;
  initial forever #5 clock_i = ~clock_i;
  cofc_host H (.clock_i(clock_i), .reg_rdata_i(rdat), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wd));
  cofc_bank DUT (.clock_i(clock_i), .srst_i(srst_i), .link_mode_i(mode), .psi5_prog_i(prog), .otp_load_i(otp),
    .otp_ch0_cfg_i(o0), .otp_ch1_cfg_i(o1), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_hit_o(), .array_check_o(), .ch0_user_gain_shift_i(sh), .ch0_user_gain_multiplier_i(mul),
    .ch1_user_gain_shift_i(sh), .ch1_user_gain_multiplier_i(mul), .ch0_sample_i(smp), .ch1_sample_i(smp),
    .ch0_raw_i(raw), .ch1_raw_i(raw), .temperature_i(tmp), .ch0_result_word0_o(r0), .ch1_result_word0_o(r1),
    .ch0_secondary_output_type_sel_o(), .ch1_secondary_output_type_sel_o(s1), .ch0_interp_avg_o(),
    .ch1_interp_avg_o(i1), .ch0_avg_period_cycles_o(p0), .ch1_avg_period_cycles_o(p1), .dsp_reset_o(),
    .dsp_ready_o(rdy));
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      failures++;
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    H.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  // cfg writes to both channels, then result words once the data path is ready
  task res(input logic [7:0] c, input logic [15:0] e);
    H.wr(8'h42, c);
    H.wr(8'h4A, c);
    for (k = 0; k < 400 && rdy !== 2'b11; k++) @(posedge clock_i);
    if (k == 400)
    begin
      failures++;
      stop_test();
    end
    repeat (4) @(posedge clock_i);
    chk(r0, e);
    chk(r1, e);
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    rc(8'h42, `COFC_CFG_RESET);
    rc(8'h4A, `COFC_CFG_RESET);
    for (int m = 0; m < 4; m++)
    begin
      mode <= m[2:0];
      prog <= (m == 3);
      // channel 1 first, so channel 0 is read back right after its own write
      H.wr(8'h4A, 8'hE0 + m[7:0]);
      H.wr(8'h42, 8'h1C + m[7:0]);
      rc(8'h42, 8'h1C + m[7:0]);
      rc(8'h4A, 8'hE0 + m[7:0]);
      chk({2'b00, p0}, (m == 0) ? 16'h0000 : 16'(`COFC_CYC_32 << (m - 1)));
      chk({2'b00, p1}, (m == 0) ? 16'h0000 : 16'(`COFC_CYC_32 << (m - 1)));
      chk({14'h0000, i1}, (m == 0) ? 16'h0001 : 16'h0002);
    end
    $display("modes and average codes done");
    prog <= 1'b0;
    H.wr(8'h42, 8'hFF);
    rc(8'h42, 8'h00);
    mode <= 3'h4;
    rc(8'h4A, 8'h00);
    mode <= 3'h1;
    rc(8'h42, 8'h1F);
    H.wr(8'h43, 8'h55);
    rc(8'h43, 8'h00);
    $display("refusals done");
    res(8'h00, 16'h0100);
    for (int s = 0; s < 4; s++)
    begin
      sh <= s[1:0];
      mul <= 8'h80;
      repeat (4) @(posedge clock_i);
      chk(r0, 16'((32'h0000_0100 * 32'h0000_0180) >> (10 - s)));
    end
    sh <= 2'h2;
    mul <= 8'h00;
    res(8'h80, 16'h8100);
    res(8'h20, 16'h0222);
    res(8'h40, 16'h0333);
    res(8'h60, 16'h0333);
    $display("result formats done");
    o0 <= 8'h5A;
    o1 <= 8'hA5;
    otp <= 1'b1;
    @(posedge clock_i);
    otp <= 1'b0;
    rc(8'h42, 8'h5A);
    rc(8'h4A, 8'hA5);
    chk({13'h0000, s1}, 16'h0001);
    chk({14'h0000, i1}, 16'h0002);
    chk({2'b00, p1}, 16'(`COFC_CYC_32));
    $display("otp load done");
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    rc(8'h42, `COFC_CFG_RESET);
    rc(8'h4A, `COFC_CFG_RESET);
    $display("mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
